// ==== sim/boot_image_loader_chk.sv ====
// Port checker for the boot image loader.
// Assumes one clock domain and the boot_pkg pin and RAM structs.
`timescale 1ns/10ps
`include "boot_params.svh"

module boot_image_loader_chk (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic pulldown_en_o,
    input wire logic otp_rd_o,
    input wire logic [`OTP_AW-1:0] otp_addr_o,
    input wire boot_pkg::qspi_pins_t qspi_o,
    input wire boot_pkg::ram_wr_t ram_o,
    input wire logic run_o,
    input wire logic [`RAM_AW-1:0] start_addr_o,
    input wire logic boot_err_o,
    input wire logic boot_otp_o
);
    import boot_pkg::*;
    logic [10:0] cyc_ff, nxt_cyc;
    logic rd_seen_ff, nxt_rd_seen, wr_seen_ff, nxt_wr_seen;
    logic [`RAM_AW-1:0] last_ff, nxt_last;

    ////////////////////////////////////////
    // Saturating count, so late boots stay checkable
    always_comb begin
        nxt_cyc = (cyc_ff == 11'h7ff) ? cyc_ff : cyc_ff + 11'h001;
        nxt_rd_seen = rd_seen_ff | otp_rd_o;
        nxt_wr_seen = wr_seen_ff | ram_o.we;
        nxt_last = ram_o.we ? ram_o.addr : last_ff;
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cyc_ff <= 11'h000;
            rd_seen_ff <= 1'b0;
            wr_seen_ff <= 1'b0;
            last_ff <= '0;
        end else begin
            cyc_ff <= nxt_cyc;
            rd_seen_ff <= nxt_rd_seen;
            wr_seen_ff <= nxt_wr_seen;
            last_ff <= nxt_last;
        end
    end

    ////////////////////////////////////////
    default clocking dclk @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    AST_INT_RESET: assert property (cyc_ff < 11'(`RST_DLY_CYC) |-> pulldown_en_o)
        else $error("pull-downs released during internal reset");
    AST_BOOT_BY: assert property (cyc_ff == 11'h5dc |-> !pulldown_en_o)
        else $error("boot not begun in time");
    AST_QUIET_DELAY: assert property (pulldown_en_o |-> !otp_rd_o && qspi_o.cs_n && !ram_o.we)
        else $error("activity during internal reset");
    AST_SEC_FIRST: assert property (otp_rd_o && !rd_seen_ff |-> otp_addr_o == `SEC_ROW)
        else $error("first read is not the security row");
    AST_SRC_EXCL: assert property (!qspi_o.cs_n |-> !boot_otp_o)
        else $error("flash selected in OTP boot");
    AST_RUN_OK: assert property (run_o |-> !boot_err_o && start_addr_o == `START_ADDR)
        else $error("start with error or nonzero address");
    AST_RUN_HOLDS: assert property (run_o |=> run_o && !ram_o.we && qspi_o.cs_n)
        else $error("activity after start");
    AST_WE_PULSE: assert property (ram_o.we |=> !ram_o.we)
        else $error("RAM write longer than one cycle");
    AST_ADDR_STEP: assert property (ram_o.we |->
        (wr_seen_ff ? ram_o.addr == last_ff + 15'h0001 : ram_o.addr == `START_ADDR))
        else $error("RAM address out of sequence");
    AST_IDLE_CLK: assert property (qspi_o.cs_n |-> !qspi_o.sclk)
        else $error("flash clock runs while deselected");
endmodule

bind boot_image_loader boot_image_loader_chk chk_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .pulldown_en_o(pulldown_en_o), .otp_rd_o(otp_rd_o), .otp_addr_o(otp_addr_o),
    .qspi_o(qspi_o), .ram_o(ram_o), .run_o(run_o), .start_addr_o(start_addr_o),
    .boot_err_o(boot_err_o), .boot_otp_o(boot_otp_o));

// ==== sim/qspi_flash_model.sv ====
// Behavioural quad-SPI boot flash: serves its image from address zero.
// Assumes 32 command/address clocks and 8 dummies before quad data.
`timescale 1ns/10ps

module qspi_flash_model (
    input wire boot_pkg::qspi_pins_t pins_i,
    output logic [3:0] d_o
);
    import boot_pkg::*;
    byte unsigned img[$];
    int rises;
    int k;
    logic [7:0] b;
    logic [3:0] last;
    logic [31:0] cmd;

    initial begin
        rises = 0;
        last = 4'h0;
        d_o = 4'hf;
    end
    always @(negedge pins_i.cs_n) rises = 0;
    // Released lines show inverse, not the last value
    always @(posedge pins_i.cs_n) d_o <= ~last;
    // command and address bits on d[0], first clock first
    always @(posedge pins_i.sclk) begin
        if (!pins_i.cs_n) begin
            if (rises < 32) cmd = {cmd[30:0], pins_i.d[0]};
            rises++;
        end
    end
    always @(negedge pins_i.sclk) begin
        if (!pins_i.cs_n && rises >= 40) begin
            k = rises - 40;
            b = (k / 2 < img.size()) ? img[k / 2] : (8'h5a ^ k[7:0]);
            last = k[0] ? b[3:0] : b[7:4];
            d_o <= last;
        end
    end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the boot image loader.
// Assumes flash model on the quad pins and an OTP responder here.
`timescale 1ns/10ps
`include "boot_params.svh"

module testbench;
    import boot_pkg::*;
    logic mclk_i, rstn_i, otp_valid_i;
    logic [31:0] otp_rdata_i, sec_word;
    logic [3:0] qspi_d_i, flash_d;
    logic pulldown_en_o, otp_rd_o, run_o, boot_err_o, boot_otp_o;
    logic [`OTP_AW-1:0] otp_addr_o, row;
    logic [`RAM_AW-1:0] start_addr_o;
    qspi_pins_t qspi_o;
    ram_wr_t ram_o;
    integer seed = 19;
    int error_cnt = 0;
    int n_checks = 0;
    int wr_idx = 0;
    logic [31:0] words[$];
    byte unsigned img[$];

    assign qspi_d_i = (qspi_o.d & qspi_o.d_oe) | (flash_d & ~qspi_o.d_oe);

    boot_image_loader dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .pulldown_en_o(pulldown_en_o),
        .otp_rd_o(otp_rd_o), .otp_addr_o(otp_addr_o), .otp_rdata_i(otp_rdata_i),
        .otp_valid_i(otp_valid_i), .qspi_d_i(qspi_d_i), .qspi_o(qspi_o), .ram_o(ram_o),
        .run_o(run_o), .start_addr_o(start_addr_o), .boot_err_o(boot_err_o),
        .boot_otp_o(boot_otp_o));
    qspi_flash_model flash_u (.pins_i(qspi_o), .d_o(flash_d));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] crc_ref(input byte unsigned q[$]);
        logic [31:0] c;
        c = 32'hffffffff;
        foreach (q[i]) begin
            c ^= {24'h000000, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
        end
        return ~c;
    endfunction

    // Mode 0 good check value, 1 skip value, 2 corrupted value, 3 oversize count
    task automatic build(input int n, input int mode);
        logic [31:0] c;
        words = {};
        img = {};
        words.push_back(n);
        for (int i = 0; i < n; i++) words.push_back($random(seed));
        if (mode == 3) words[0] = `RAM_WORDS + 32'h00000001;
        foreach (words[i]) for (int j = 0; j < 4; j++) img.push_back(words[i][8*j +: 8]);
        c = crc_ref(img);
        words.push_back(mode == 1 ? 32'h0d15ab1e : (mode == 2 ? c ^ 32'h00000100 : c));
        for (int j = 0; j < 4; j++) img.push_back(words[n + 1][8*j +: 8]);
    endtask

    task automatic boot(input bit otp, input int n, input int mode, input bit abort);
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        build(n, mode);
        sec_word = $random(seed);
        sec_word[5] = otp;
        flash_u.img = img;
        wr_idx = 0;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("pulldown in reset", pulldown_en_o, 1'b1);
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (140) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("pulldown in delay", pulldown_en_o, 1'b1);
        if (abort) begin
            repeat (300) @(posedge mclk_i);
            return;
        end
        for (int t = 0; t < 3000 && run_o !== 1'b1 && boot_err_o !== 1'b1; t++)
            @(posedge mclk_i);
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("run", run_o, mode < 2);
        chk("error", boot_err_o, mode >= 2);
        chk("start address", start_addr_o, 0);
        chk("source", boot_otp_o, otp);
        chk("word count", wr_idx, (mode == 3) ? 0 : n);
        chk("flash released", qspi_o.cs_n, 1'b1);
        if (!otp) chk("flash command", flash_u.cmd, {`FLASH_RD_CMD, 24'h000000});
    endtask

    ////////////////////////////////////////
    always @(posedge mclk_i) begin
        if (rstn_i === 1'b1 && ram_o.we === 1'b1) begin
            chk("ram addr", ram_o.addr, wr_idx);
            chk("ram data", ram_o.data, words[wr_idx + 1]);
            wr_idx++;
        end
    end

    // OTP answers after a random wait; image rows start at row 0
    initial begin
        otp_valid_i = 1'b0;
        otp_rdata_i = 32'h00000000;
        forever begin
            @(posedge mclk_i);
            if (otp_rd_o === 1'b1) begin
                row = otp_addr_o;
                repeat ($unsigned($random(seed)) % 3) @(posedge mclk_i);
                otp_valid_i <= 1'b1;
                otp_rdata_i <= (row == `SEC_ROW) ? sec_word : words[row];
                @(posedge mclk_i);
                otp_valid_i <= 1'b0;
                otp_rdata_i <= ~otp_rdata_i;
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        $display("unexpected timeout: run did not end");
        give_verdict();
    end

    initial begin
        rstn_i = 1'b0;
        repeat (16) @(posedge mclk_i);
        boot(1'b0, 3, 0, 1'b1);
        for (int m = 0; m < 3; m++) boot(1'b0, 2 + m, m, 1'b0);
        boot(1'b0, 0, 0, 1'b0);
        boot(1'b0, 1, 3, 1'b0);
        for (int m = 0; m < 3; m++) boot(1'b1, 2, m, 1'b0);
        give_verdict();
    end
endmodule

// ==== src/boot_image_loader.sv ====
// Boot sequencer: internal reset, boot-source pick, image load, CRC check.
// Assumes an OTP read port with a valid strobe and an SRAM word write port.
//
// Operation
// (RL1) In reset the device stays reset with pull-downs on all pins.
// (RL2) After release, run internal reset delay 15-150 us, then boot.
// (RL3) Security bit 5 set boots from OTP, else internal flash.
// (RL4) Flash boot reads the quad-SPI flash through tile 0 ports.
// (RL5) Image starts with word count s; s times four bytes follow.
// (RL6) A 32-bit trailer follows; magic skip value disables CRC check.
// (RL7) Size and trailer are read least significant byte first.
// (RL8) Program loads from lowest RAM address and starts there.
// (RL9) CRC covers size bytes and program bytes, not the trailer.
// (RL10) Reflected IEEE 802.3 CRC-32 polynomial, bytes LSB first.
// (RL11) CRC preset to all ones; final residue inverted before compare.
// (RL12) Security register loads from OTP before the source is chosen.
// (RL13) Secure boot starts reading from OTP address zero, bypassing ROM.
// (RL14) OTP contents copy into SRAM and run before anything else.
// (RL15) CRC mismatch keeps the program stopped and flags boot error.
`timescale 1ns/10ps
`include "boot_params.svh"

module boot_image_loader (
    input wire logic mclk_i,
    input wire logic rstn_i,
    output logic pulldown_en_o,
    output logic otp_rd_o,
    output logic [`OTP_AW-1:0] otp_addr_o,
    input wire logic [31:0] otp_rdata_i,
    input wire logic otp_valid_i,
    input wire logic [3:0] qspi_d_i,
    output boot_pkg::qspi_pins_t qspi_o,
    output boot_pkg::ram_wr_t ram_o,
    output logic run_o,
    output logic [`RAM_AW-1:0] start_addr_o,
    output logic boot_err_o,
    output logic boot_otp_o
);
    import boot_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    boot_state_t st_ff, nxt_st;
    logic [`RST_CNT_W-1:0] dly_ff, nxt_dly;
    logic [31:0] sec_ff, nxt_sec;
    logic otp_src_ff, nxt_otp_src;
    logic [1:0] idx_ff, nxt_idx;
    logic [31:0] asm_ff, nxt_asm;
    logic [31:0] left_ff, nxt_left;
    logic [`RAM_AW-1:0] waddr_ff, nxt_waddr;
    ram_wr_t ram_ff, nxt_ram;
    logic pd_ff, nxt_pd;
    logic run_ff, nxt_run;
    logic err_ff, nxt_err;
    logic flash_run_ff, nxt_flash_run;
    logic [`RAM_AW-1:0] start_ff, nxt_start;

    logic [`OTP_AW-1:0] oaddr_ff, nxt_oaddr;
    logic ord_ff, nxt_ord;
    logic owait_ff, nxt_owait;
    logic [31:0] obuf_ff, nxt_obuf;
    logic [2:0] ocnt_ff, nxt_ocnt;

    logic streaming, in_sec;
    logic [7:0] fl_byte, in_byte;
    logic fl_vld, in_vld;
    logic [31:0] word;
    logic crc_init, crc_en;
    logic [31:0] crc_res;
    qspi_pins_t qspi_pins;

    assign streaming = (st_ff == ST_SIZE) || (st_ff == ST_BODY) || (st_ff == ST_TRAIL);
    assign in_sec = (st_ff == ST_SEC);
    assign in_byte = otp_src_ff ? obuf_ff[7:0] : fl_byte;
    assign in_vld = streaming && (otp_src_ff ? (ocnt_ff != 3'h0) : fl_vld);
    // (RL7) Bytes fill from the top, so the first lands lowest
    assign word = {in_byte, asm_ff[31:8]};

    ////////////////////////////////////////////////////////////////////////
    // (RL4) Flash stream on tile 0 ports
    qspi_reader u_qspi (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .run_i(flash_run_ff),
        .qspi_d_i(qspi_d_i),
        .pins_o(qspi_pins),
        .byte_o(fl_byte),
        .byte_vld_o(fl_vld)
    );

    // (RL9) Size and body bytes only
    assign crc_en = in_vld && (st_ff != ST_TRAIL);
    assign crc_init = (st_ff == ST_PICK);

    crc32_byte u_crc (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .init_i(crc_init),
        .en_i(crc_en),
        .byte_i(in_byte),
        .crc_o(crc_res)
    );

    ////////////////////////////////////////////////////////////////////////
    // OTP fetch: security row first, then image words from row zero
    always_comb begin
        nxt_oaddr = oaddr_ff;
        nxt_ord = 1'b0;
        nxt_owait = owait_ff;
        nxt_obuf = obuf_ff;
        nxt_ocnt = ocnt_ff;
        if (otp_valid_i && owait_ff) begin
            nxt_owait = 1'b0;
            nxt_obuf = otp_rdata_i;
            nxt_ocnt = in_sec ? 3'h0 : 3'h4;
            // Row advances once its word is in hand, so row zero is read first
            if (!in_sec) begin
                nxt_oaddr = oaddr_ff + `OTP_AW'(1);
            end
        end else if (in_sec && !owait_ff) begin
            // (RL12) Security row fetch
            nxt_ord = 1'b1;
            nxt_owait = 1'b1;
            nxt_oaddr = `SEC_ROW;
        end else if (st_ff == ST_PICK) begin
            // (RL13) Image read starts at OTP row zero
            nxt_oaddr = `OTP_START;
            nxt_ocnt = 3'h0;
        end else if (in_vld && otp_src_ff) begin
            nxt_obuf = obuf_ff >> 8;
            nxt_ocnt = ocnt_ff - 3'h1;
        end else if (streaming && otp_src_ff && ocnt_ff == 3'h0 && !owait_ff) begin
            // (RL14) Copy OTP words into the load stream
            nxt_ord = 1'b1;
            nxt_owait = 1'b1;
            // Address already points at the next row
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oaddr_ff <= `OTP_START;
            ord_ff <= 1'b0;
            owait_ff <= 1'b0;
            obuf_ff <= 32'h00000000;
            ocnt_ff <= 3'h0;
        end else begin
            oaddr_ff <= nxt_oaddr;
            ord_ff <= nxt_ord;
            owait_ff <= nxt_owait;
            obuf_ff <= nxt_obuf;
            ocnt_ff <= nxt_ocnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot sequence
    always_comb begin
        nxt_st = st_ff;
        nxt_dly = dly_ff;
        nxt_sec = sec_ff;
        nxt_otp_src = otp_src_ff;
        nxt_idx = idx_ff;
        nxt_asm = asm_ff;
        nxt_left = left_ff;
        nxt_waddr = waddr_ff;
        nxt_ram = ram_ff;
        nxt_ram.we = 1'b0;
        nxt_pd = pd_ff;
        nxt_run = run_ff;
        nxt_err = err_ff;
        nxt_flash_run = flash_run_ff;
        nxt_start = start_ff;
        if (in_vld) begin
            nxt_asm = word;
            nxt_idx = idx_ff + 2'h1;
        end
        case (st_ff)
            ST_RESET: begin
                // (RL2) Internal reset delay, then boot
                if (dly_ff == `RST_CNT_W'(`RST_DLY_CYC - 1)) begin
                    nxt_st = ST_SEC;
                    nxt_pd = 1'b0;
                end else begin
                    nxt_dly = dly_ff + `RST_CNT_W'(1);
                end
            end
            ST_SEC: begin
                if (otp_valid_i && owait_ff) begin
                    nxt_sec = otp_rdata_i;
                    nxt_st = ST_PICK;
                end
            end
            ST_PICK: begin
                // (RL3) Source from security bit
                nxt_otp_src = sec_ff[`SEC_BOOT_BIT];
                nxt_flash_run = ~sec_ff[`SEC_BOOT_BIT];
                nxt_idx = 2'h0;
                nxt_st = ST_SIZE;
            end
            ST_SIZE: begin
                // (RL5) Word count, then body or trailer, or error if above RAM_WORDS
                if (in_vld && idx_ff == `BYTE_LAST) begin
                    nxt_left = word;
                    nxt_waddr = `START_ADDR;
                    if (word == 32'h00000000) begin
                        nxt_st = ST_TRAIL;
                    end else if (word > `RAM_WORDS) begin
                        nxt_st = ST_ERR;
                    end else begin
                        nxt_st = ST_BODY;
                    end
                end
            end
            ST_BODY: begin
                // (RL8) Words from the lowest RAM address up
                if (in_vld && idx_ff == `BYTE_LAST) begin
                    nxt_ram.we = 1'b1;
                    nxt_ram.addr = waddr_ff;
                    nxt_ram.data = word;
                    nxt_waddr = waddr_ff + `RAM_AW'(1);
                    nxt_left = left_ff - 32'h00000001;
                    if (left_ff == 32'h00000001) begin
                        nxt_st = ST_TRAIL;
                    end
                end
            end
            ST_TRAIL: begin
                if (in_vld && idx_ff == `BYTE_LAST) begin
                    nxt_st = ST_CHECK;
                    nxt_flash_run = 1'b0;
                end
            end
            ST_CHECK: begin
                // (RL6) Skip value bypasses the check
                // (RL11) Inverted residue against trailer
                if (asm_ff == `CRC_SKIP || asm_ff == ~crc_res) begin
                    nxt_st = ST_RUN;
                    nxt_run = 1'b1;
                    // (RL8) Start where the load began
                    nxt_start = `START_ADDR;
                end else begin
                    // (RL15) Mismatch stops the boot
                    nxt_st = ST_ERR;
                end
            end
            ST_RUN: begin
                // Sticky until reset; flash stays deselected
                nxt_flash_run = 1'b0;
            end
            ST_ERR: begin
                nxt_err = 1'b1;
                nxt_flash_run = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff <= ST_RESET;
            dly_ff <= '0;
            sec_ff <= 32'h00000000;
            otp_src_ff <= 1'b0;
            idx_ff <= 2'h0;
            asm_ff <= 32'h00000000;
            left_ff <= 32'h00000000;
            waddr_ff <= `START_ADDR;
            ram_ff <= '{we: 1'b0, addr: `START_ADDR, data: 32'h00000000};
            // (RL1) Pull-downs on while in reset
            pd_ff <= 1'b1;
            run_ff <= 1'b0;
            err_ff <= 1'b0;
            flash_run_ff <= 1'b0;
            start_ff <= `START_ADDR;
        end else begin
            st_ff <= nxt_st;
            dly_ff <= nxt_dly;
            sec_ff <= nxt_sec;
            otp_src_ff <= nxt_otp_src;
            idx_ff <= nxt_idx;
            asm_ff <= nxt_asm;
            left_ff <= nxt_left;
            waddr_ff <= nxt_waddr;
            ram_ff <= nxt_ram;
            pd_ff <= nxt_pd;
            run_ff <= nxt_run;
            err_ff <= nxt_err;
            flash_run_ff <= nxt_flash_run;
            start_ff <= nxt_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign pulldown_en_o = pd_ff;
    assign otp_rd_o = ord_ff;
    assign otp_addr_o = oaddr_ff;
    assign qspi_o = qspi_pins;
    assign ram_o = ram_ff;
    assign run_o = run_ff;
    // (RL8) Execution starts at the load address
    assign start_addr_o = start_ff;
    assign boot_err_o = err_ff;
    assign boot_otp_o = otp_src_ff;

endmodule

// ==== src/boot_params.svh ====
// Constants of the boot image loader: timing, image format, memory sizes.
// Included by every design file; definitions only.
`ifndef BOOT_PARAMS_SVH
`define BOOT_PARAMS_SVH

// Internal reset delay, least figure, in microseconds
`define RST_DLY_US 15
`define CLK_MHZ 10
`define RST_DLY_CYC (`RST_DLY_US * `CLK_MHZ)
`define RST_CNT_W 8

// Security register row in OTP and its boot-source bit
`define SEC_ROW 11'h7ff
`define SEC_BOOT_BIT 5
`define OTP_AW 11
`define OTP_START 11'h000

// Image format
`define CRC_POLY 32'hedb88320
`define CRC_INIT 32'hffffffff
`define CRC_SKIP 32'h0d15ab1e
`define BYTE_LAST 2'h3

// SRAM: 128 KB as 32-bit words
`define RAM_AW 15
`define RAM_WORDS 32'h00008000
`define START_ADDR 15'h0000

// Quad-SPI flash read
`define FLASH_RD_CMD 8'h6b
`define SEND_BITS 5'h1f
`define DUMMY_CLKS 5'h07
`define SPI_DIV_LAST 2'h1
`define QSPI_OE_SERIAL 4'h1
`define QSPI_OE_NONE 4'h0

`endif

// ==== src/boot_pkg.sv ====
// Types shared by the boot image loader and its leaves.
// Assumes boot_params.svh for the widths it names.
`include "boot_params.svh"

package boot_pkg;

    typedef enum logic [3:0] {
        ST_RESET, ST_SEC, ST_PICK, ST_SIZE, ST_BODY, ST_TRAIL, ST_CHECK, ST_RUN, ST_ERR
    } boot_state_t;

    typedef enum logic [2:0] {
        QS_IDLE, QS_SEND, QS_DUMMY, QS_DATA
    } qspi_state_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] d;
        logic [3:0] d_oe;
    } qspi_pins_t;

    typedef struct packed {
        logic we;
        logic [`RAM_AW-1:0] addr;
        logic [31:0] data;
    } ram_wr_t;

endpackage

// ==== src/crc32_byte.sv ====
// Reflected CRC-32, one byte per enabled cycle, LSB first.
// Assumes init and en are never high together.
`timescale 1ns/10ps
`include "boot_params.svh"

module crc32_byte (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic init_i,
    input wire logic en_i,
    input wire logic [7:0] byte_i,
    output logic [31:0] crc_o
);
    import boot_pkg::*;

    logic [31:0] crc_ff;
    logic [31:0] nxt_crc;
    logic [31:0] stage [0:8];

    assign stage[0] = crc_ff;

    // (RL10) One reflected step per bit
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign stage[i+1] = (stage[i] >> 1) ^
                (`CRC_POLY & {32{stage[i][0] ^ byte_i[i]}});
        end
    endgenerate

    always_comb begin
        nxt_crc = crc_ff;
        // (RL11) Preset to all ones
        if (init_i) begin
            nxt_crc = `CRC_INIT;
        end else if (en_i) begin
            nxt_crc = stage[8];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_ff <= `CRC_INIT;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc_o = crc_ff;

endmodule

// ==== src/qspi_reader.sv ====
// Quad-SPI flash reader: quad-output read from address zero, byte stream out.
// Assumes the flash takes the command and address on d[0], most significant bit first.
`timescale 1ns/10ps
`include "boot_params.svh"

module qspi_reader (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [3:0] qspi_d_i,
    output boot_pkg::qspi_pins_t pins_o,
    output logic [7:0] byte_o,
    output logic byte_vld_o
);
    import boot_pkg::*;

    qspi_state_t st_ff, nxt_st;
    logic [1:0] div_ff, nxt_div;
    logic [31:0] sh_ff, nxt_sh;
    logic [4:0] cnt_ff, nxt_cnt;
    logic hi_ff, nxt_hi;
    qspi_pins_t pins_ff, nxt_pins;
    logic [7:0] byte_ff, nxt_byte;
    logic vld_ff, nxt_vld;
    logic tick;

    // Slow clock as an enable; sclk is half the tick rate
    assign tick = (div_ff == `SPI_DIV_LAST);

    always_comb begin
        nxt_st = st_ff;
        nxt_div = tick ? 2'h0 : div_ff + 2'h1;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_hi = hi_ff;
        nxt_pins = pins_ff;
        nxt_byte = byte_ff;
        nxt_vld = 1'b0;
        if (!run_i) begin
            // Stop ends the frame at once, whatever the phase
            nxt_st = QS_IDLE;
            nxt_pins.cs_n = 1'b1;
            nxt_pins.sclk = 1'b0;
            nxt_pins.d_oe = `QSPI_OE_NONE;
        end else if (st_ff == QS_IDLE) begin
            // (RL4) Command and address zero on the tile 0 pins
            nxt_st = QS_SEND;
            nxt_sh = {`FLASH_RD_CMD, 24'h000000};
            nxt_cnt = `SEND_BITS;
            nxt_hi = 1'b0;
            nxt_pins.cs_n = 1'b0;
            nxt_pins.d = {3'h0, nxt_sh[31]};
            nxt_pins.d_oe = `QSPI_OE_SERIAL;
        end else if (tick) begin
            nxt_pins.sclk = ~pins_ff.sclk;
            if (!pins_ff.sclk) begin
                // Rising edge: sample data nibbles
                if (st_ff == QS_DATA) begin
                    nxt_hi = ~hi_ff;
                    nxt_byte = {byte_ff[3:0], qspi_d_i};
                    nxt_vld = hi_ff;
                end
            end else begin
                // Falling edge: shift out, count phases
                case (st_ff)
                    QS_SEND: begin
                        nxt_sh = sh_ff << 1;
                        nxt_pins.d = {3'h0, sh_ff[30]};
                        if (cnt_ff == 5'h00) begin
                            nxt_st = QS_DUMMY;
                            nxt_cnt = `DUMMY_CLKS;
                            nxt_pins.d_oe = `QSPI_OE_NONE;
                        end else begin
                            nxt_cnt = cnt_ff - 5'h01;
                        end
                    end
                    QS_DUMMY: begin
                        if (cnt_ff == 5'h00) begin
                            nxt_st = QS_DATA;
                        end else begin
                            nxt_cnt = cnt_ff - 5'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff <= QS_IDLE;
            div_ff <= 2'h0;
            sh_ff <= 32'h00000000;
            cnt_ff <= 5'h00;
            hi_ff <= 1'b0;
            pins_ff <= '{cs_n: 1'b1, sclk: 1'b0, d: 4'h0, d_oe: 4'h0};
            byte_ff <= 8'h00;
            vld_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            hi_ff <= nxt_hi;
            pins_ff <= nxt_pins;
            byte_ff <= nxt_byte;
            vld_ff <= nxt_vld;
        end
    end

    assign pins_o = pins_ff;
    assign byte_o = byte_ff;
    assign byte_vld_o = vld_ff;

endmodule
